// >>> inc/fadc_consts.svh
// Constants of the flash converter sample and output logic.
// Assumes a 20 MHz system clock; included by the package and the design files.
`ifndef FADC_CONSTS_SVH
`define FADC_CONSTS_SVH

`define FADC_CODE_W      7
`define FADC_AN_W        16
`define FADC_THRESH_NUM  128
`define FADC_CODE_MAX    7'h7F
`define FADC_CODE_MID    7'h40
`define FADC_CODE_RST    7'h00
`define FADC_SYS_MHZ     20
`define FADC_PROP_NS     22
`define FADC_PROP_CYC    (((`FADC_PROP_NS * `FADC_SYS_MHZ) / 1000) > 0 ? \
                          ((`FADC_PROP_NS * `FADC_SYS_MHZ) / 1000) : 1)
`define FADC_CNT_W       4

`endif

// >>> inc/fadc_pkg.sv
// Types shared by the flash converter sample and output logic.
// Assumes the constants header sits beside it on the include path.
`include "fadc_consts.svh"

package fadc_pkg;

	// Digital stand-in for the analog pins, signed, one common unit
	typedef struct packed {
		logic signed [`FADC_AN_W-1:0] vin;
		logic signed [`FADC_AN_W-1:0] ladderTopVoltage;
		logic signed [`FADC_AN_W-1:0] ladderBottomVoltage;
	} fadc_analog_t;

	// Output select pin: driven level plus a flag for an open pin
	typedef struct packed {
		logic level;
		logic open;
	} fadc_sel_t;

	// One conversion result
	typedef struct packed {
		logic [`FADC_CODE_W-1:0] code;
		logic                    over;
	} fadc_result_t;

	// Clock phase of the conversion sequence
	typedef enum logic [2:0] {
		FADC_TRACK  = 3'b001,
		FADC_SETTLE = 3'b010,
		FADC_PASS   = 3'b100
	} fadc_phase_t;

endpackage : fadc_pkg

// >>> core/fadc_quantizer.sv
// Comparator array and encoder: ladder thresholds to a natural binary code.
// Assumes a positive span between the ladder ends; purely combinational.
`timescale 1ns/1ps
`include "fadc_consts.svh"

module fadc_quantizer
	import fadc_pkg::*;
(
	input  wire fadc_analog_t analogIn,
	output fadc_result_t      result
);

	// Counts the thresholds below x; threshold k sits at (2k-1)/256 of span
	function automatic logic [7:0] fadc_count(
		input logic signed [31:0] x,
		input logic signed [31:0] span,
		input int                 lastK
	);
		logic [7:0] n;
		int         k;
		n = 8'h00;
		for (k = 1; k <= lastK; k++) begin
			if (x > (2 * k - 1) * span) begin
				n = n + 8'h01;
			end
		end
		return n;
	endfunction : fadc_count

	wire logic signed [31:0] diffScaled;
	wire logic signed [31:0] span;
	wire logic        [7:0]  codeCount;
	wire logic        [7:0]  overCount;

	// Input offset scaled by two steps per threshold pitch
	assign diffScaled = 32'(analogIn.vin - analogIn.ladderBottomVoltage) * 32'sd256;
	assign span       = 32'(analogIn.ladderTopVoltage - analogIn.ladderBottomVoltage);

	// Lower 127 thresholds form the code; count stops at all ones
	assign codeCount   = fadc_count(diffScaled, span, `FADC_THRESH_NUM - 1);
	assign result.code = codeCount[`FADC_CODE_W-1:0];

	// Top threshold alone decides overrange, half a step below the top
	assign overCount   = fadc_count(diffScaled, span, `FADC_THRESH_NUM);
	assign result.over = (overCount == 8'(`FADC_THRESH_NUM));

endmodule : fadc_quantizer

// >>> core/fadc_out_stage.sv
// Output latches and the three-state control of the code bits.
// Assumes the load strobe comes from the phase logic of the top.
`timescale 1ns/1ps
`include "fadc_consts.svh"

module fadc_out_stage
	import fadc_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	input  wire logic               loadEn,
	input  wire fadc_result_t       heldResult,
	input  wire fadc_sel_t          selTrue,
	input  wire fadc_sel_t          selInv,
	output logic [`FADC_CODE_W-1:0] codeBitsOut,
	output logic                    codeBitsOe,
	output logic                    overrangeOut
);

	fadc_result_t outQ;
	wire logic    selTrueEff;
	wire logic    selInvEff;

	// Open pins read as high; both ends still should be tied
	assign selTrueEff = selTrue.level | selTrue.open;
	assign selInvEff  = selInv.level | selInv.open;

	// Drive only for true high and inverted low
	assign codeBitsOe = selTrueEff & ~selInvEff;

	// Latch follows the held result while open, holds otherwise
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			outQ <= '{code: `FADC_CODE_RST, over: 1'b0};
		end else if (loadEn) begin
			outQ <= heldResult;
		end
	end

	// Code pins carry the latch even while released
	assign codeBitsOut  = outQ.code;
	assign overrangeOut = outQ.over;

endmodule : fadc_out_stage

// >>> core/fadc_top.sv
// Sample, convert and output control of a 7-bit flash converter.
// Assumes convClk and the analog stand-ins are synchronous to sys_clk.
`timescale 1ns/1ps
`include "fadc_consts.svh"

module fadc_top
	import fadc_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	input  wire logic               convClk,
	input  wire fadc_analog_t       analogIn,
	input  wire fadc_sel_t          selTrue,
	input  wire fadc_sel_t          selInv,
	output logic [`FADC_CODE_W-1:0] codeBitsOut,
	output logic                    codeBitsOe,
	output logic                    overrangeOut
);

	localparam logic [`FADC_CNT_W-1:0] PROP_LOAD = `FADC_CNT_W'(`FADC_PROP_CYC - 1);

	logic                   convClkQ;
	fadc_phase_t            phaseQ;
	fadc_phase_t            phaseD;
	logic [`FADC_CNT_W-1:0] propCntQ;
	logic [`FADC_CNT_W-1:0] propCntD;
	fadc_result_t           holdQ;
	fadc_result_t           liveResult;
	wire logic              clkFall;
	wire logic              clkRise;
	wire logic              settleDone;
	wire logic              loadEn;

	// Comparators see the input continuously; freezing is done by holdQ
	fadc_quantizer u_quant (
		.analogIn (analogIn),
		.result   (liveResult)
	);

	// Edge detection on the converter clock against its last sample, no added latency
	assign clkFall = convClkQ & ~convClk;
	assign clkRise = ~convClkQ & convClk;

	// Each phase must span one system cycle or an edge is missed
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			convClkQ <= 1'b0;
		end else begin
			convClkQ <= convClk;
		end
	end

	// Propagation delay elapsed inside the low phase
	assign settleDone = (phaseQ == FADC_SETTLE) && (propCntQ == '0);

	// Output latch open once the code has settled; still open on the rise edge
	// so a short low phase never drops its result
	assign loadEn = settleDone || (phaseQ == FADC_PASS);

	// Phase sequencer
	always_comb begin
		phaseD   = phaseQ;
		propCntD = propCntQ;
		case (phaseQ)
			FADC_TRACK: begin
				if (clkFall) begin
					phaseD   = FADC_SETTLE;
					propCntD = PROP_LOAD;
				end
			end
			FADC_SETTLE: begin
				if (clkRise) begin
					phaseD = FADC_TRACK;
				end else if (propCntQ == '0) begin
					phaseD = FADC_PASS;
				end else begin
					propCntD = propCntQ - `FADC_CNT_W'(1);
				end
			end
			FADC_PASS: begin
				if (clkRise) begin
					phaseD = FADC_TRACK;
				end
			end
			default: begin
				phaseD   = FADC_TRACK;
				propCntD = '0;
			end
		endcase
	end

	// Phase registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			phaseQ   <= FADC_TRACK;
			propCntQ <= '0;
		end else begin
			phaseQ   <= phaseD;
			propCntQ <= propCntD;
		end
	end

	// Comparator latch: captured only at the fall, frozen until the next
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			holdQ <= '{code: `FADC_CODE_RST, over: 1'b0};
		end else if (clkFall) begin
			holdQ <= liveResult;
		end
	end

	// Output latches and pin drivers
	fadc_out_stage u_out (
		.sys_clk      (sys_clk),
		.rst_b        (rst_b),
		.loadEn       (loadEn),
		.heldResult   (holdQ),
		.selTrue      (selTrue),
		.selInv       (selInv),
		.codeBitsOut  (codeBitsOut),
		.codeBitsOe   (codeBitsOe),
		.overrangeOut (overrangeOut)
	);

	// Checks on the conversion sequence

	// Helper: widened arithmetic for the threshold checks
	wire logic signed [31:0] chkDiff;
	wire logic signed [31:0] chkSpan;
	assign chkDiff = 32'(analogIn.vin - analogIn.ladderBottomVoltage);
	assign chkSpan = 32'(analogIn.ladderTopVoltage - analogIn.ladderBottomVoltage);

	sequence s_fall;
		clkFall && (phaseQ != FADC_SETTLE);
	endsequence

	property p_holdOnFall;
		@(posedge sys_clk) disable iff (!rst_b)
		clkFall |=> (holdQ == $past(liveResult));
	endproperty
	a_holdOnFall: assert property (p_holdOnFall)
		else $error("comparator latch missed the falling edge");

	property p_propDelay;
		@(posedge sys_clk) disable iff (!rst_b)
		s_fall ##1 !clkRise |=> (codeBitsOut == $past(holdQ.code));
	endproperty
	a_propDelay: assert property (p_propDelay)
		else $error("new code late at the outputs");

	property p_trackHold;
		@(posedge sys_clk) disable iff (!rst_b)
		(phaseQ == FADC_TRACK) |=> $stable(codeBitsOut) && $stable(overrangeOut);
	endproperty
	a_trackHold: assert property (p_trackHold)
		else $error("output changed during the high phase");

	property p_riseCloses;
		@(posedge sys_clk) disable iff (!rst_b)
		clkRise |=> (phaseQ == FADC_TRACK);
	endproperty
	a_riseCloses: assert property (p_riseCloses)
		else $error("output latch left open after rise");

	property p_frozenLow;
		@(posedge sys_clk) disable iff (!rst_b)
		(!convClk && !convClkQ) |=> $stable(holdQ);
	endproperty
	a_frozenLow: assert property (p_frozenLow)
		else $error("comparator latch moved in low phase");

	property p_passLow;
		@(posedge sys_clk) disable iff (!rst_b)
		(phaseQ == FADC_PASS) |=> (codeBitsOut == $past(holdQ.code))
			&& (overrangeOut == $past(holdQ.over));
	endproperty
	a_passLow: assert property (p_passLow)
		else $error("output latch not transparent in low phase");

	property p_driveOn;
		@(posedge sys_clk) disable iff (!rst_b)
		(selTrue.level && !selTrue.open && !selInv.level && !selInv.open) |-> codeBitsOe;
	endproperty
	a_driveOn: assert property (p_driveOn)
		else $error("code bits not driven when enabled");

	property p_driveOff;
		@(posedge sys_clk) disable iff (!rst_b)
		(!selTrue.level && !selTrue.open) || selInv.level |-> !codeBitsOe;
	endproperty
	a_driveOff: assert property (p_driveOff)
		else $error("code bits driven while disabled");

	property p_openPin;
		@(posedge sys_clk) disable iff (!rst_b)
		selInv.open |-> !codeBitsOe;
	endproperty
	a_openPin: assert property (p_openPin)
		else $error("open inverted select not read as high");

	property p_convWhileOff;
		@(posedge sys_clk) disable iff (!rst_b)
		(!codeBitsOe && clkFall) |=> (holdQ == $past(liveResult));
	endproperty
	a_convWhileOff: assert property (p_convWhileOff)
		else $error("conversion stalled by the selects");

	property p_overThresh;
		@(posedge sys_clk) disable iff (!rst_b)
		(chkSpan > 0) |-> (liveResult.over == (chkDiff * 256 > chkSpan * 255));
	endproperty
	a_overThresh: assert property (p_overThresh)
		else $error("overrange threshold misplaced");

	property p_lowThresh;
		@(posedge sys_clk) disable iff (!rst_b)
		(chkSpan > 0 && chkDiff * 256 <= chkSpan) |-> (liveResult.code == `FADC_CODE_RST);
	endproperty
	a_lowThresh: assert property (p_lowThresh)
		else $error("code not zero below lowest threshold");

	property p_saturate;
		@(posedge sys_clk) disable iff (!rst_b)
		liveResult.over |-> (liveResult.code == `FADC_CODE_MAX);
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("code not saturated in overrange");

	property p_midCode;
		@(posedge sys_clk) disable iff (!rst_b)
		(chkSpan > 0 && chkDiff * 2 == chkSpan) |-> (liveResult.code == `FADC_CODE_MID);
	endproperty
	a_midCode: assert property (p_midCode)
		else $error("midpoint input gave wrong binary code");

	property p_fallToSettle;
		@(posedge sys_clk) disable iff (!rst_b)
		(phaseQ == FADC_TRACK) && clkFall |=> (phaseQ == FADC_SETTLE);
	endproperty
	a_fallToSettle: assert property (p_fallToSettle)
		else $error("fall did not start the settle phase");

	property p_settleToPass;
		@(posedge sys_clk) disable iff (!rst_b)
		(phaseQ == FADC_SETTLE) && (propCntQ == '0) && !clkRise |=> (phaseQ == FADC_PASS);
	endproperty
	a_settleToPass: assert property (p_settleToPass)
		else $error("settled code did not open the output latch");

	property p_riseLoads;
		@(posedge sys_clk) disable iff (!rst_b)
		settleDone && clkRise |=> (codeBitsOut == $past(holdQ.code)) && (overrangeOut == $past(holdQ.over));
	endproperty
	a_riseLoads: assert property (p_riseLoads)
		else $error("short low phase dropped its result");

	property p_settleCount;
		@(posedge sys_clk) disable iff (!rst_b)
		(phaseQ == FADC_SETTLE) |-> (propCntQ <= PROP_LOAD);
	endproperty
	a_settleCount: assert property (p_settleCount)
		else $error("settle count out of range");

	property p_phaseLegal;
		@(posedge sys_clk) disable iff (!rst_b)
		$onehot(phaseQ);
	endproperty
	a_phaseLegal: assert property (p_phaseLegal)
		else $error("phase register not one-hot");

	property p_holdOnlyAtFall;
		@(posedge sys_clk) disable iff (!rst_b)
		!clkFall |=> $stable(holdQ);
	endproperty
	a_holdOnlyAtFall: assert property (p_holdOnlyAtFall)
		else $error("comparator latch moved without a fall");

	property p_topCode;
		@(posedge sys_clk) disable iff (!rst_b)
		(chkSpan > 0 && chkDiff * 256 > chkSpan * 253) |-> (liveResult.code == `FADC_CODE_MAX);
	endproperty
	a_topCode: assert property (p_topCode)
		else $error("code not all ones above the top code threshold");

	// Main scenarios
	c_conversion: cover property (@(posedge sys_clk) disable iff (!rst_b)
		clkFall ##1 loadEn ##1 codeBitsOe);
	c_overrange: cover property (@(posedge sys_clk) disable iff (!rst_b)
		overrangeOut && !codeBitsOe);
	c_shortLow: cover property (@(posedge sys_clk) disable iff (!rst_b)
		clkFall ##1 clkRise);
	c_released: cover property (@(posedge sys_clk) disable iff (!rst_b)
		!codeBitsOe ##1 codeBitsOe);
	c_riseLoad: cover property (@(posedge sys_clk) disable iff (!rst_b)
		settleDone && clkRise);

endmodule : fadc_top

// >>> test/fadc_reader.sv
// Far-side model: makes the converter clock and reads the code bus.
// Assumes the bench calls clk_period just after a falling sys_clk edge.
`timescale 1ns/1ps
`include "fadc_consts.svh"

module fadc_reader (
	input  wire logic                    sys_clk,
	input  wire logic [`FADC_CODE_W-1:0] codeBitsOut,
	input  wire logic                    codeBitsOe,
	output logic                         convClk,
	output logic [`FADC_CODE_W-1:0]      busSeen
);
	logic [`FADC_CODE_W-1:0] lastQ;

	initial convClk = 1'b0;

	// Released bus shows the inverse of the last value, never a stale copy
	always @(posedge sys_clk) begin
		if (codeBitsOe)
			lastQ <= codeBitsOut;
	end
	assign busSeen = codeBitsOe ? codeBitsOut : ~lastQ;

	// One converter period; each phase is whole sys_clk cycles, at least one
	task automatic clk_period(input int hi, input int lo);
		convClk = 1'b1;
		repeat (hi) @(negedge sys_clk);
		convClk = 1'b0;
		repeat (lo) @(negedge sys_clk);
	endtask : clk_period
endmodule : fadc_reader

// >>> test/fadc_top_tb.sv
// Self-checking bench of the flash converter sample and output logic.
// Assumes a ladder of 0 to 0x500, so one step is 0x0A; no reset of its own on the far side.
`timescale 1ns/1ps
`include "fadc_consts.svh"

module fadc_top_tb
	import fadc_pkg::*;
;
	logic                    sys_clk;
	logic                    rst_b;
	logic                    convClk;
	fadc_analog_t            analogIn;
	fadc_sel_t               selTrue;
	fadc_sel_t               selInv;
	logic [`FADC_CODE_W-1:0] codeBitsOut;
	logic                    codeBitsOe;
	logic                    overrangeOut;
	logic [`FADC_CODE_W-1:0] busSeen;
	int                      failures;
	int                      checksDone;
	int                      cycleCount;

	fadc_top fadc_top_inst (
		.sys_clk      (sys_clk),
		.rst_b        (rst_b),
		.convClk      (convClk),
		.analogIn     (analogIn),
		.selTrue      (selTrue),
		.selInv       (selInv),
		.codeBitsOut  (codeBitsOut),
		.codeBitsOe   (codeBitsOe),
		.overrangeOut (overrangeOut)
	);

	fadc_reader fadc_reader_inst (
		.sys_clk     (sys_clk),
		.codeBitsOut (codeBitsOut),
		.codeBitsOe  (codeBitsOe),
		.convClk     (convClk),
		.busSeen     (busSeen)
	);

	// 20 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check_code(input logic [`FADC_CODE_W-1:0] got, input logic [`FADC_CODE_W-1:0] exp);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t code %h expected %h", $time, got, exp);
		end
	endtask : check_code

	task automatic check_bit(input logic got, input logic exp);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// Sweep across both ends and both strict thresholds
	task automatic run_table();
		logic [15:0] vins[9] = '{16'h0000, 16'h0005, 16'h0006, 16'h0280, 16'h04F1,
			16'h04F6, 16'h04FB, 16'h04FC, 16'hFF9C};
		logic [6:0] codes[9] = '{7'h00, 7'h00, 7'h01, 7'h40, 7'h7E, 7'h7F, 7'h7F, 7'h7F, 7'h00};
		logic overs[9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 9; i++) begin
			analogIn.vin = vins[i];
			fadc_reader_inst.clk_period(1, 2);
			check_code(busSeen, codes[i]);
			check_bit(overrangeOut, overs[i]);
		end
	endtask : run_table

	// Old code stands until one cycle after the fall; low and high phases hold it
	task automatic run_hold();
		analogIn.vin = 16'h0280;
		fork
			fadc_reader_inst.clk_period(1, 2);
			begin
				@(negedge sys_clk);
				check_code(busSeen, 7'h00);
			end
		join
		analogIn.vin = 16'h04FC;
		@(negedge sys_clk);
		check_code(busSeen, 7'h40);
		fork
			fadc_reader_inst.clk_period(3, 1);
			begin
				repeat (2) @(negedge sys_clk);
				check_code(busSeen, 7'h40);
				check_bit(overrangeOut, 1'b0);
			end
		join
		@(negedge sys_clk);
		check_code(busSeen, 7'h7F);
		check_bit(overrangeOut, 1'b1);
	endtask : run_hold

	// Every select combination, open pins included; conversion runs while released
	task automatic run_selects();
		for (int i = 0; i < 16; i++) begin
			@(negedge sys_clk);
			selTrue = i[3:2];
			selInv = i[1:0];
			@(posedge sys_clk);
			check_bit(codeBitsOe, (i[3] | i[2]) & ~(i[1] | i[0]));
		end
		@(negedge sys_clk);
		selTrue = 2'b00;
		analogIn.vin = 16'h0006;
		fadc_reader_inst.clk_period(1, 2);
		check_bit(codeBitsOe, 1'b0);
		check_bit(overrangeOut, 1'b0);
		selTrue = 2'b10;
		selInv = 2'b00;
		@(negedge sys_clk);
		check_bit(codeBitsOe, 1'b1);
		check_code(busSeen, 7'h01);
	endtask : run_selects

	// Back-to-back periods with one-cycle low phases; the result loads on the rise
	task automatic run_short();
		analogIn.vin = 16'h04F1;
		fadc_reader_inst.clk_period(1, 1);
		analogIn.vin = 16'h0280;
		fadc_reader_inst.clk_period(1, 1);
		check_code(busSeen, 7'h7E);
		fadc_reader_inst.clk_period(1, 1);
		check_code(busSeen, 7'h40);
	endtask : run_short

	// Hang guard; the run needs some 76 cycles
	always @(posedge sys_clk) begin
		cycleCount++;
		if (cycleCount == 2000) begin
			failures++;
			print_verdict();
		end
	end

	// Reset, then the scenarios in order
	initial begin
		failures = 0;
		checksDone = 0;
		cycleCount = 0;
		rst_b = 1'b0;
		analogIn.vin = 16'h0000;
		analogIn.ladderTopVoltage = 16'h0500;
		analogIn.ladderBottomVoltage = 16'h0000;
		selTrue = 2'b10;
		selInv = 2'b00;
		repeat (12) @(negedge sys_clk);
		rst_b = 1'b1;
		@(negedge sys_clk);
		check_code(codeBitsOut, 7'h00);
		check_bit(overrangeOut, 1'b0);
		run_table();
		run_hold();
		run_selects();
		run_short();
		print_verdict();
	end
endmodule : fadc_top_tb
